/* tsr_pkg.sv */
// constants shared by the sensor readout top and its conversion core
package tsr_pkg;
  // ************************************************************
  // register widths and layouts
  // ************************************************************
  localparam int          REG_W         = 16;
  localparam int          RES_W         = 13;
  localparam int          RES_LSB       = 3;
  localparam int          FIRST_BIT     = 2;
  localparam logic [15:0] MODE_RESET    = 16'h0000;
  localparam logic [7:0]  SHUTDOWN_CODE = 8'hFF;
  localparam logic [5:0]  MAKER_ZERO_W  = 6'h00;
  // ************************************************************
  // serial framing, counted in sampled clock rises
  // ************************************************************
  localparam int          CNT_W         = 6;
  localparam logic [5:0]  CNT_MAX       = 6'h3F;
  localparam logic [5:0]  DRIVE_BITS    = 6'h0E;
  localparam logic [5:0]  WRITE_START   = 6'h10;
  localparam logic [5:0]  WRITE_LAST    = 6'h1F;
  localparam logic [5:0]  MAKER_START   = 6'h20;
  localparam logic [5:0]  MAKER_END     = 6'h2E;
  // ************************************************************
  // conversion timing
  // ************************************************************
  localparam int          CLK_HZ        = 40000000;
  localparam int          CONV_TIME_MS  = 300;
  localparam int          CONV_CYCLES   = (CONV_TIME_MS * (CLK_HZ / 1000));
  localparam int          CONV_CNT_W    = 24;
endpackage : tsr_pkg

/* tsr_conv_if.sv */
// signals between the serial front end and the conversion core
`timescale 1ns/1ps
interface tsr_conv_if;
  logic                        run;
  logic [tsr_pkg::RES_W-1:0]   result;
  logic                        first_done;
  modport core (input run, output result, output first_done);
  modport ctrl (output run, input result, input first_done);
endinterface : tsr_conv_if

/* tsr_conv.sv */
// conversion core: paced conversions, result register and first-done flag
`timescale 1ns/1ps
module tsr_conv #(
  parameter int CONV_CYCLES = tsr_pkg::CONV_CYCLES
) (
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  input  wire logic [tsr_pkg::RES_W-1:0] sense_code,
  tsr_conv_if.core                       cif
);
  logic [tsr_pkg::CONV_CNT_W-1:0] cnt;
  logic [tsr_pkg::CONV_CNT_W-1:0] next_cnt;
  logic [tsr_pkg::RES_W-1:0]      result;
  logic [tsr_pkg::RES_W-1:0]      next_result;
  logic                           first_done;
  logic                           next_first_done;
  localparam logic [tsr_pkg::CONV_CNT_W-1:0] LAST =
    tsr_pkg::CONV_CNT_W'(CONV_CYCLES - 1);

  // ************************************************************
  // conversion pacing
  // ************************************************************
  // a conversion already under way runs to its end even in shutdown
  always_comb begin
    next_cnt        = cnt;
    next_result     = result;
    next_first_done = first_done;
    // [R17] no new start in shutdown
    if (cif.run || (cnt != '0)) begin
      if (cnt == LAST) begin
        next_cnt        = '0;
        next_result     = sense_code;
        // [R09] flag set on completion
        next_first_done = 1'b1;
      end else begin
        next_cnt = cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt        <= '0;
      result     <= '0;
      first_done <= 1'b0;
    end else begin
      cnt        <= next_cnt;
      result     <= next_result;
      first_done <= next_first_done;
    end
  end

  assign cif.result     = result;
  assign cif.first_done = first_done;
endmodule : tsr_conv

/* tsr_top.sv */
// serial readout top: synchronisers, framing, mode word and readout shifter
//
// Functional notes
// [R01] three 16-bit registers, two read-only, one write-only
// [R02] low byte all ones selects shutdown
// [R03] any zero in low byte: continuous conversion
// [R04] reset into continuous mode, low byte zero
// [R05] master writes only all-zero or all-one codes; the bench also writes mixed low bytes such as 01 and 7F
// [R06] serial port keeps working during shutdown
// [R07] result in bits 15:3, two's complement
// [R08] reading bits 1:0 left undriven
// [R09] bit 2 set after first conversion completes
// [R10] maker code readable only in shutdown
// [R11] maker code high byte, zeros, undriven 1:0
// [R12] chip select frames transfer, clock ignored otherwise
// [R13] first bit at select, shift on falls, release after 14
// [R14] 16 pulses read out, next 16 write mode
// [R15] early deselect aborts read, conversions continue
// [R16] after shutdown write, maker code shifts out
// [R17] shutdown stops new conversions, keeps last result
`timescale 1ns/1ps
module tsr_top #(
  parameter int          CONV_CYCLES = tsr_pkg::CONV_CYCLES,
  parameter logic [7:0]  MAKER_CODE  = 8'hA5  // arbitrary value
) (
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  input  wire logic                      cs_n,
  input  wire logic                      sck,
  input  wire logic                      sio_in,
  output      logic                      sio_out,
  output      logic                      sio_oe,
  input  wire logic [tsr_pkg::RES_W-1:0] sense_code,
  output      logic                      shutdown
);
  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic                       cs_s1, cs_s2, cs_s3;
  logic                       sck_s1, sck_s2, sck_s3;
  logic                       sio_s1, sio_s2;
  logic                       cs_fall, selected, sck_rise, sck_fall;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cs_s1  <= 1'b1;
      cs_s2  <= 1'b1;
      cs_s3  <= 1'b1;
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_s3 <= 1'b0;
      sio_s1 <= 1'b0;
      sio_s2 <= 1'b0;
    end else begin
      cs_s1  <= cs_n;
      cs_s2  <= cs_s1;
      cs_s3  <= cs_s2;
      sck_s1 <= sck;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      sio_s1 <= sio_in;
      sio_s2 <= sio_s1;
    end
  end

  // edges come from the second and third stages only
  // [R12] clock edges count only while selected
  assign selected = ~cs_s2;
  assign cs_fall  = cs_s3 & ~cs_s2;
  assign sck_rise = selected & ~sck_s3 & sck_s2;
  assign sck_fall = selected & sck_s3 & ~sck_s2;

  // ************************************************************
  // conversion core
  // ************************************************************
  tsr_conv_if cif ();

  tsr_conv #(
    .CONV_CYCLES (CONV_CYCLES)
  ) u_conv (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .sense_code (sense_code),
    .cif        (cif)
  );

  // ************************************************************
  // register images
  // ************************************************************
  // [R01] three 16-bit register images
  logic [tsr_pkg::REG_W-1:0] mode_control_word;
  logic [tsr_pkg::REG_W-1:0] thermal_reading_reg;
  logic [tsr_pkg::REG_W-1:0] maker_code_reg;
  logic                      mode_shut;

  // [R02] shutdown decode on the low byte only
  assign mode_shut = (mode_control_word[7:0] == tsr_pkg::SHUTDOWN_CODE);
  // [R17] new conversions start only outside shutdown
  assign cif.run   = ~mode_shut;
  // [R07] result above the first-done flag
  // [R09] first-done flag in bit 2
  assign thermal_reading_reg = {cif.result, cif.first_done, 2'b00};
  // [R11] code, zeros, two bits never driven
  assign maker_code_reg      = {MAKER_CODE, tsr_pkg::MAKER_ZERO_W, 2'b00};

  // ************************************************************
  // framing, shifters and mode word
  // ************************************************************
  logic [tsr_pkg::CNT_W-1:0] bitcnt, next_bitcnt;
  logic [tsr_pkg::REG_W-1:0] shreg, next_shreg;
  logic [tsr_pkg::REG_W-1:0] rxreg, next_rxreg;
  logic [tsr_pkg::REG_W-1:0] next_mode;
  logic                      maker_on, next_maker_on;
  logic                      next_sio_oe;

  // the port stays live in shutdown: nothing here looks at the mode
  // except the maker load, so reads and writes always go through
  // [R06] port live in shutdown
  always_comb begin
    next_bitcnt   = bitcnt;
    next_shreg    = shreg;
    next_rxreg    = rxreg;
    next_mode     = mode_control_word;
    next_maker_on = maker_on;
    if (cs_fall) begin
      // [R13] first bit ready at select
      next_bitcnt   = '0;
      next_shreg    = thermal_reading_reg;
      next_maker_on = 1'b0;
    end else if (selected) begin
      if (sck_rise) begin
        if (bitcnt != tsr_pkg::CNT_MAX) begin
          next_bitcnt = bitcnt + 1'b1;
        end
        // [R14] second group of pulses writes
        if ((bitcnt >= tsr_pkg::WRITE_START) && (bitcnt <= tsr_pkg::WRITE_LAST)) begin
          next_rxreg = {rxreg[14:0], sio_s2};
        end
        // [R03] full word replaces the mode
        if (bitcnt == tsr_pkg::WRITE_LAST) begin
          next_mode = {rxreg[14:0], sio_s2};
        end
      end
      if (sck_fall) begin
        // [R16] maker code after shutdown write
        // [R10] only while in shutdown
        if ((bitcnt == tsr_pkg::MAKER_START) && mode_shut) begin
          next_shreg    = maker_code_reg;
          next_maker_on = 1'b1;
        end else begin
          // [R13] shift on falling clock
          next_shreg = {shreg[14:0], 1'b0};
        end
      end
    end
  end

  // output enable follows the next frame state so it lines up with data
  always_comb begin
    next_sio_oe = 1'b0;
    if (~cs_s2) begin
      // [R13] release after 14 bits
      // [R08] bits 1:0 stay undriven
      if (next_bitcnt < tsr_pkg::DRIVE_BITS) begin
        next_sio_oe = 1'b1;
      end else if (next_maker_on && (next_bitcnt >= tsr_pkg::MAKER_START)
                   && (next_bitcnt < tsr_pkg::MAKER_END)) begin
        next_sio_oe = 1'b1;
      end
    end
  end

  // [R15] deselect just drops the drive, the core is untouched
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bitcnt            <= tsr_pkg::CNT_MAX;
      shreg             <= '0;
      rxreg             <= '0;
      // [R04] continuous mode after reset
      mode_control_word <= tsr_pkg::MODE_RESET;
      maker_on          <= 1'b0;
      sio_out           <= 1'b0;
      sio_oe            <= 1'b0;
      shutdown          <= 1'b0;
    end else begin
      bitcnt            <= next_bitcnt;
      shreg             <= next_shreg;
      rxreg             <= next_rxreg;
      mode_control_word <= next_mode;
      maker_on          <= next_maker_on;
      sio_out           <= next_shreg[15];
      sio_oe            <= next_sio_oe;
      shutdown          <= (next_mode[7:0] == tsr_pkg::SHUTDOWN_CODE);
    end
  end
endmodule : tsr_top

/* tsr_props.sv */
// checker on the readout pins
`timescale 1ns/1ps
module tsr_props #(parameter int CONV_CYCLES = 50) (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        cs_n,
  input wire logic        sck,
  input wire logic        sio_in,
  input wire logic        sio_out,
  input wire logic        sio_oe,
  input wire logic [12:0] sense_code,
  input wire logic        shutdown
);
  logic [6:0] trk;
  logic [6:0] next_trk;
  // sck rises while selected in [6:1], last sck level in [0]
  always_comb next_trk = {cs_n ? 6'h00 : trk[6:1] + {5'h00, sck & ~trk[0]}, sck};
  // reset clears the count so a new run starts from pulse zero
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst) trk <= 7'h00;
    else trk <= next_trk;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_idle_quiet: assert property (cs_n [*6] |-> !sio_oe)
    else $error("data line driven while deselected");
  chk_first_bit: assert property ($fell(cs_n) |-> ##[3:5] sio_oe)
    else $error("first bit not presented");
  chk_read_drive: assert property (!cs_n && trk[6:1] inside {[1:13]} |-> sio_oe)
    else $error("reading bit undriven");
  chk_release_after: assert property (trk[6:1] inside {[15:31]} |-> !sio_oe)
    else $error("line not released");
  chk_maker_gate: assert property (!shutdown && trk[6:1] >= 6'h21 |-> !sio_oe)
    else $error("maker word outside shutdown");
  chk_mode_on: assert property ($rose(shutdown) |-> !cs_n && trk[6:1] == 6'h20)
    else $error("shutdown not at pulse 32");
  chk_mode_off: assert property ($fell(shutdown) |-> !cs_n && trk[6:1] == 6'h20)
    else $error("continuous not at pulse 32");
  chk_out_stable: assert property (!cs_n && sck && $past(sck, 2) |-> $stable(sio_out))
    else $error("data moved while clock high");
endmodule : tsr_props
bind tsr_top tsr_props #(.CONV_CYCLES(CONV_CYCLES)) u_tsr_props (.clk, .sys_rst, .cs_n,
  .sck, .sio_in, .sio_out, .sio_oe, .sense_code, .shutdown);

/* tsr_master.sv */
// behavioural serial master for the readout bench
`timescale 1ns/1ps
module tsr_master (
  input  wire logic clk,
  input  wire logic sio_out,
  input  wire logic sio_oe,
  output      logic cs_n,
  output      logic sck,
  output      logic sio_w
);
  logic m_en  = 1'h0;
  logic m_dat = 1'h0;
  // idle levels at time zero
  initial {cs_n, sck} = 2'h2;
  // no pull on the line, so a released line shows the inverse of the last bit
  assign sio_w = sio_oe ? sio_out : (m_en ? m_dat : ~sio_out);
  task automatic frame(input int n, input logic [15:0] wr, input logic idle,
                       output logic [47:0] rx, output logic [47:0] oe);
    @(negedge clk) cs_n <= idle;
    repeat (8) @(negedge clk);
    for (int i = 0; i < n; i++) begin
      repeat (2) @(negedge clk);
      m_en  <= i >= 16 && i < 32;
      m_dat <= wr[(31 - i) & 15];
      repeat (2) @(negedge clk);
      sck <= 1'h1;
      repeat (2) @(negedge clk);
      {rx[47 - i], oe[47 - i]} = {sio_w, sio_oe};
      repeat (2) @(negedge clk);
      sck <= 1'h0;
    end
    repeat (8) @(negedge clk);
    cs_n <= 1'h1;
    m_en <= 1'h0;
    repeat (4) @(negedge clk);
  endtask : frame
endmodule : tsr_master

/* testbench.sv */
// self-checking bench for the sensor readout top
`timescale 1ns/1ps
module testbench;
  // ********************************
  // stimulus, expectations, checks
  // ********************************
  localparam int         CC = 50;
  localparam logic [7:0] MC = 8'h3C;  // arbitrary value
  logic        clk = 1'h0;
  logic        sys_rst = 1'h1;
  logic [12:0] sense_code = 13'h0000;
  logic [12:0] v;
  logic        cs_n, sck, sio_w, sio_out, sio_oe, shutdown;
  logic [47:0] rx, oe;
  logic [31:0] seed = 32'h60DF;
  int          err_count = 0, checks = 0, cyc = 0;
  // 40 MHz clock and a ceiling on run length
  always #12.5 clk = ~clk;
  always @(posedge clk) if (++cyc == 20000) close_out(1);
  tsr_top #(.CONV_CYCLES(CC), .MAKER_CODE(MC)) u_tsr_top (.clk, .sys_rst, .cs_n, .sck,
    .sio_in(sio_w), .sio_out, .sio_oe, .sense_code, .shutdown);
  tsr_master u_tsr_master (.clk, .sio_out, .sio_oe, .cs_n, .sck, .sio_w);
  // random source and expected reading word, undriven pair masked
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [15:0] rd_word(input logic [12:0] r, input logic f);
    return {r, f, 2'h0};
  endfunction : rd_word
  task automatic cmp(input string what, input logic [15:0] want, got);
    checks++;
    if (got !== want) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, want, got);
    end
  endtask : cmp
  task automatic close_out(input int hung);
    err_count += hung;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out
  task automatic rst_dut();
    @(negedge clk) sys_rst <= 1'h1;
    repeat (4) @(negedge clk);
    sys_rst <= 1'h0;
    repeat (6) @(negedge clk);
  endtask : rst_dut
  // one selection, then reading, enables, maker word and mode
  task automatic xfer(input int n, input logic [15:0] wr, er, input logic sd);
    u_tsr_master.frame(n, wr, 1'h0, rx, oe);
    if (n >= 16) cmp("reading", er, {rx[47:34], 2'h0});
    if (n >= 16) cmp("read enable", 16'hFFFC, oe[47:32]);
    if (n == 48) cmp("maker enable", sd ? 16'hFFFC : 16'h0000, oe[15:0]);
    if (n == 48 && sd) cmp("maker", {MC, 8'h00}, {rx[15:2], 2'h0});
    cmp("shutdown", {15'h0000, sd}, {15'h0000, shutdown});
  endtask : xfer
  // random sweep of mode codes, low byte 00 up to FF, and results, then shutdown corners
  initial begin
    rst_dut();
    xfer(16, 16'h0000, rd_word(13'h0000, 1'h0), 1'h0);
    for (int k = 0; k < 9; k++) begin
      seed = lfsr(seed);
      v = seed[12:0];
      sense_code <= v;
      repeat (2 * CC) @(negedge clk);
      xfer(48, {seed[23:16], 8'hFF >> (8 - k)}, rd_word(v, 1'h1), k == 8);
    end
    repeat (2 * CC) @(negedge clk);
    sense_code <= ~v;
    repeat (3 * CC) @(negedge clk);
    xfer(48, 16'hFFFF, rd_word(v, 1'h1), 1'h1);
    xfer(24, 16'h0000, rd_word(v, 1'h1), 1'h1);
    xfer(48, 16'h0000, rd_word(v, 1'h1), 1'h0);
    repeat (2 * CC) @(negedge clk);
    xfer(5, 16'h0000, 16'h0000, 1'h0);
    xfer(16, 16'h0000, rd_word(~v, 1'h1), 1'h0);
    u_tsr_master.frame(32, 16'hFFFF, 1'h1, rx, oe);
    cmp("idle enable", 16'h0000, oe[47:32]);
    cmp("idle mode", 16'h0000, {15'h0000, shutdown});
    xfer(32, 16'h5AFF, rd_word(~v, 1'h1), 1'h1);
    rst_dut();
    cmp("reset mode", 16'h0000, {15'h0000, shutdown});
    xfer(16, 16'h0000, rd_word(13'h0000, 1'h0), 1'h0);
    close_out(0);
  end
endmodule : testbench
